// file: logic/rtc_pkg.sv
// constants, register map and helpers for the dual low-frequency counter.
// assumes one system clock; the 32 kHz sources arrive as plain pins.
package rtc_pkg;
  // source and system rates
  localparam int unsigned LF_HZ = 32768;
  localparam int unsigned SYS_HZ = 25000000;
  localparam logic [3:0] SEC_EXP = 4'h f;  // 2^15 = LF_HZ
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SEC_COUNT = 8'h0c;
  localparam logic [7:0] OFS_SEC_ALARM = 8'h10;
  localparam logic [7:0] OFS_FLEX_COUNT = 8'h14;
  localparam logic [7:0] OFS_FLEX_ALARM = 8'h18;
  localparam logic [7:0] OFS_FLEX_FINE = 8'h1c;
  localparam logic [7:0] OFS_STB_TARGET = 8'h20;
  localparam logic [7:0] OFS_STB_WIDTH = 8'h24;
  localparam logic [7:0] OFS_CAP_COUNT = 8'h28;
  localparam logic [7:0] OFS_CAP_FINE = 8'h2c;
  localparam logic [7:0] OFS_NOW_FINE = 8'h30;
  // control field positions
  localparam int CTL_SEC_EN = 0;
  localparam int CTL_FLEX_EN = 1;
  localparam int CTL_CLK_SEL = 2;
  localparam int CTL_EXP_LO = 4;
  localparam int CTL_SEC_ALM = 8;
  localparam int CTL_FLEX_ALM = 9;
  localparam int CTL_PERIODIC = 10;
  localparam int CTL_STB_EN = 11;
  localparam int CTL_CAP_EN = 12;
  localparam int CTL_CAP_FALL = 13;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // status / mask bit positions
  localparam int EV_SEC_ALM = 0;
  localparam int EV_FLEX_ALM = 1;
  localparam int EV_PERIODIC = 2;
  localparam int EV_STROBE = 3;
  localparam int EV_CAPTURE = 4;
  localparam int NEV = 5;
  localparam logic [4:0] EV_RST = 5'h00;
  // periodic alarm spacing in prescaled units
  localparam logic [5:0] PERIOD_LAST = 6'h3b;  // 60 units, 0..59
  // power modes seen on the mode input
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'h0,
    PM_CORE_GATED = 2'h1,
    PM_HIBERNATE = 2'h2,
    PM_SHUTDOWN = 2'h3
  } power_mode_t;
  // low bits set below 2^exp: prescaler wrap value
  function automatic logic [14:0] pow2_mask(input logic [3:0] e);
    logic [15:0] one;
    one = 16'h0001 << e;
    return 15'((one - 16'h0001));
  endfunction
endpackage

// file: logic/pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses.
// assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // raw pin
  input wire logic pin,
  // filtered level and one-cycle edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r;  // only read by s2_r
  logic s2_r;
  logic s3_r;
  logic lvl_r;  // accepted level
  // chain of three flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a change is taken only once stages two and three agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end
  assign level = lvl_r;
  assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
  assign fall = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule // pin_sync
`default_nettype wire

// file: logic/pow2_prescaler.sv
// power-of-two prescaler on a tick stream; phase is readable.
// assumes tick_in is a one-cycle pulse per source period.
`timescale 1ns/1ps
`default_nettype none
module pow2_prescaler
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [3:0] exp_sel,
  input wire logic tick_in,
  // results
  output logic [14:0] phase,
  output logic unit_tick
);
  logic [14:0] cnt_r;  // source ticks into current unit
  logic [14:0] mask;
  assign mask = pow2_mask(exp_sel);
  // unit ends on the tick that finds the phase at its wrap value
  assign unit_tick = run && tick_in && ((cnt_r & mask) == mask);
  assign phase = cnt_r & mask;
  // phase counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 15'h0000;
    end else if (clear || unit_tick) begin
      cnt_r <= 15'h0000;
    end else if (run && tick_in) begin
      cnt_r <= (cnt_r + 15'h0001) & mask;
    end
  end
endmodule // pow2_prescaler
`default_nettype wire

// file: logic/dual_rtc_alarm_capture.sv
// two low-frequency counters with alarms, strobe pin and input capture.
// assumes 32 kHz sources and capture pin are asynchronous pins,
// apb master on sys_clk, power mode supplied by the power manager.
`timescale 1ns/1ps
`default_nettype none
module dual_rtc_alarm_capture
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // low-frequency sources
  input wire logic low_freq_crystal,
  input wire logic low_freq_internal_osc,
  // power manager
  input wire logic [1:0] power_mode,
  output logic wake_req,
  // gpio pins
  input wire logic capture_in,
  output logic timed_strobe_output,
  // interrupt
  output logic irq
);
  // synchronised sources and capture pin
  logic xtal_tick;
  logic osc_tick;
  logic cap_rise;
  logic cap_fall;
  // registers
  logic [13:0] ctrl_r;
  logic [4:0] status_r;
  logic [4:0] mask_r;
  logic [31:0] sec_count_r;
  logic [31:0] sec_alarm_r;
  logic [31:0] flex_count_r;
  logic [31:0] flex_alarm_r;
  logic [14:0] flex_fine_r;  // alarm phase within a unit
  logic [31:0] stb_target_r;
  logic [7:0] stb_width_r;  // units, zero means one
  logic [31:0] cap_count_r;
  logic [14:0] cap_fine_r;
  logic [31:0] prdata_r;
  // internal state
  logic [5:0] period_cnt_r;
  logic [7:0] stb_left_r;  // units of pulse remaining
  logic stb_out_r;
  logic sec_match_r;
  logic flex_match_r;
  logic [14:0] flex_phase;
  logic sec_unit;
  logic flex_unit;
  logic flex_src_tick;
  logic flex_run;
  logic shutdown;
  logic [4:0] events;
  logic [4:0] status_nxt;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic sec_match;
  logic flex_match;
  logic stb_hit;
  logic cap_edge;

  // pin synchronisers
  pin_sync u_xtal (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(low_freq_crystal),
    .level(),
    .rise(xtal_tick),
    .fall()
  );
  pin_sync u_osc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(low_freq_internal_osc),
    .level(),
    .rise(osc_tick),
    .fall()
  );
  pin_sync u_cap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(capture_in),
    .level(),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // flexible clock only runs outside shutdown; seconds keeps going
  assign shutdown = (power_mode == PM_SHUTDOWN);
  assign flex_src_tick = ctrl_r[CTL_CLK_SEL] ? osc_tick : xtal_tick;
  assign flex_run = ctrl_r[CTL_FLEX_EN] && !shutdown;

  // seconds prescaler, exponent pinned to a full second
  pow2_prescaler u_sec_pre (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(ctrl_r[CTL_SEC_EN]),
    .clear(!ctrl_r[CTL_SEC_EN]),
    .exp_sel(SEC_EXP),
    .tick_in(xtal_tick),
    .phase(),
    .unit_tick(sec_unit)
  );

  // flexible prescaler, exponent from control
  pow2_prescaler u_flex_pre (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(flex_run),
    .clear(!ctrl_r[CTL_FLEX_EN]),
    .exp_sel(ctrl_r[CTL_EXP_LO+3:CTL_EXP_LO]),
    .tick_in(flex_src_tick),
    .phase(flex_phase),
    .unit_tick(flex_unit)
  );

  // apb decode: zero wait states, errors on unmapped words
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  // read mux; also serves as the address check
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {18'h0_0000, ctrl_r};
      OFS_STATUS: rd_mux = {27'h000_0000, status_r};
      OFS_MASK: rd_mux = {27'h000_0000, mask_r};
      OFS_SEC_COUNT: rd_mux = sec_count_r;
      OFS_SEC_ALARM: rd_mux = sec_alarm_r;
      OFS_FLEX_COUNT: rd_mux = flex_count_r;
      OFS_FLEX_ALARM: rd_mux = flex_alarm_r;
      OFS_FLEX_FINE: rd_mux = {17'h0_0000, flex_fine_r};
      OFS_STB_TARGET: rd_mux = stb_target_r;
      OFS_STB_WIDTH: rd_mux = {24'h00_0000, stb_width_r};
      OFS_CAP_COUNT: rd_mux = cap_count_r;
      OFS_CAP_FINE: rd_mux = {17'h0_0000, cap_fine_r};
      OFS_NOW_FINE: rd_mux = {17'h0_0000, flex_phase};
      default: addr_ok = 1'b0;  // unmapped reads zero
    endcase
  end

  // read data captured in setup, held through the access phase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  // software-only configuration registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      mask_r <= EV_RST;
      sec_alarm_r <= 32'h0000_0000;
      flex_alarm_r <= 32'h0000_0000;
      flex_fine_r <= 15'h0000;
      stb_target_r <= 32'h0000_0000;
      stb_width_r <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: ctrl_r <= pwdata[13:0];
        OFS_MASK: mask_r <= pwdata[4:0];
        OFS_SEC_ALARM: sec_alarm_r <= pwdata;
        OFS_FLEX_ALARM: flex_alarm_r <= pwdata;
        OFS_FLEX_FINE: flex_fine_r <= pwdata[14:0];
        OFS_STB_TARGET: stb_target_r <= pwdata;
        OFS_STB_WIDTH: stb_width_r <= pwdata[7:0];
        default: ;  // count and status writes have their own process; capture and phase are read-only
      endcase
    end
  end

  // seconds count: a write loads it, else one step per second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sec_count_r <= 32'h0000_0000;
    end else if (wr_en && paddr == OFS_SEC_COUNT) begin
      sec_count_r <= pwdata;
    end else if (sec_unit) begin
      sec_count_r <= sec_count_r + 32'h0000_0001;
    end
  end

  // flexible count: one step per prescaled unit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flex_count_r <= 32'h0000_0000;
    end else if (wr_en && paddr == OFS_FLEX_COUNT) begin
      flex_count_r <= pwdata;
    end else if (flex_unit) begin
      flex_count_r <= flex_count_r + 32'h0000_0001;
    end
  end

  // alarm matches; only the first cycle of a match fires, so an
  // absolute alarm cannot repeat while the count sits on it
  assign sec_match = ctrl_r[CTL_SEC_ALM] && (sec_count_r == sec_alarm_r);
  assign flex_match = ctrl_r[CTL_FLEX_ALM] && flex_run
    && (flex_count_r == flex_alarm_r)
    && (flex_phase == (flex_fine_r & pow2_mask(ctrl_r[CTL_EXP_LO+3:CTL_EXP_LO])));
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sec_match_r <= 1'b0;
      flex_match_r <= 1'b0;
    end else begin
      sec_match_r <= sec_match;
      flex_match_r <= flex_match;
    end
  end

  // periodic alarm: every sixtieth unit while enabled
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_cnt_r <= 6'h00;
    end else if (!ctrl_r[CTL_PERIODIC]) begin
      period_cnt_r <= 6'h00;  // restart spacing on enable
    end else if (flex_unit) begin
      if (period_cnt_r == PERIOD_LAST) begin
        period_cnt_r <= 6'h00;
      end else begin
        period_cnt_r <= period_cnt_r + 6'h01;
      end
    end
  end

  // strobe starts on the unit step that lands on the target
  assign stb_hit = ctrl_r[CTL_STB_EN] && flex_unit
    && ((flex_count_r + 32'h0000_0001) == stb_target_r);

  // strobe pulse: width in units, zero taken as one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stb_out_r <= 1'b0;
      stb_left_r <= 8'h00;
    end else if (!ctrl_r[CTL_STB_EN]) begin
      stb_out_r <= 1'b0;  // disabling cuts a pulse short
      stb_left_r <= 8'h00;
    end else if (stb_hit) begin
      stb_out_r <= 1'b1;
      stb_left_r <= (stb_width_r == 8'h00) ? 8'h01 : stb_width_r;
    end else if (flex_unit && stb_out_r) begin
      stb_left_r <= stb_left_r - 8'h01;
      if (stb_left_r == 8'h01) begin
        stb_out_r <= 1'b0;
      end
    end
  end
  assign timed_strobe_output = stb_out_r;

  // capture edge select; pin may move in any power mode
  assign cap_edge = ctrl_r[CTL_CAP_EN]
    && (ctrl_r[CTL_CAP_FALL] ? cap_fall : cap_rise);

  // snapshot count and phase, so the exact source cycle is kept
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cap_count_r <= 32'h0000_0000;
      cap_fine_r <= 15'h0000;
    end else if (cap_edge) begin
      cap_count_r <= flex_count_r;
      cap_fine_r <= flex_phase;
    end
  end

  // event vector for the sticky status
  assign events[EV_SEC_ALM] = sec_match && !sec_match_r;
  assign events[EV_FLEX_ALM] = flex_match && !flex_match_r;
  assign events[EV_PERIODIC] = ctrl_r[CTL_PERIODIC] && flex_unit
    && (period_cnt_r == PERIOD_LAST);
  assign events[EV_STROBE] = stb_hit;
  assign events[EV_CAPTURE] = cap_edge;

  // write-one-to-clear, but a new event in the same cycle survives
  always_comb begin
    status_nxt = status_r;
    if (wr_en && paddr == OFS_STATUS) begin
      status_nxt = status_r & ~pwdata[4:0];
    end
    status_nxt = status_nxt | events;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= EV_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(status_r & mask_r);

  // wake: only the seconds alarm can reach a shut-down chip
  always_comb begin
    if (power_mode == PM_ACTIVE) begin
      wake_req = 1'b0;  // already awake
    end else if (shutdown) begin
      wake_req = status_r[EV_SEC_ALM] && mask_r[EV_SEC_ALM];
    end else begin
      wake_req = irq;
    end
  end
endmodule // dual_rtc_alarm_capture
`default_nettype wire

// file: verif/dual_rtc_alarm_capture_assertions.sv
// port-level checker for the dual counter block, bound to its top.
// assumes sys_clk domain only; power_mode is synchronous to it.
`timescale 1ns/1ps
`default_nettype none
module dual_rtc_alarm_capture_checker
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // power and pins
  input wire logic [1:0] power_mode,
  input wire logic wake_req,
  input wire logic timed_strobe_output,
  input wire logic irq
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // access phase of any transfer
  wire logic acc = psel && penable;
  chk_ready_high: assert property (psel |-> pready)
    else $error("pready low during transfer");
  chk_err_unmap: assert property (acc && paddr > OFS_NOW_FINE |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && paddr <= OFS_NOW_FINE
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped access");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  chk_rd_unmap: assert property (psel && !penable && !pwrite
    && paddr > OFS_NOW_FINE |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_mask_off: assert property (acc && pwrite && paddr == OFS_MASK
    && pwdata[4:0] == 5'h00 |=> !irq) else $error("irq with empty mask");
  chk_wake_idle: assert property ((power_mode == PM_ACTIVE)[*2]
    |-> !wake_req) else $error("wake request in active mode");
  chk_wake_irq: assert property ((power_mode == PM_CORE_GATED
    || power_mode == PM_HIBERNATE)[*2] |-> wake_req == irq)
    else $error("wake request differs from irq");
  chk_stb_frozen: assert property ((power_mode == PM_SHUTDOWN)[*2]
    |-> $stable(timed_strobe_output)) else $error("strobe moved in shutdown");
  // main scenarios reached
  cover property (acc && pslverr);
  cover property ($rose(irq));
  cover property ($rose(timed_strobe_output));
endmodule // dual_rtc_alarm_capture_checker
bind dual_rtc_alarm_capture dual_rtc_alarm_capture_checker u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
  .wake_req(wake_req), .timed_strobe_output(timed_strobe_output),
  .irq(irq)
);
`default_nettype wire

// file: verif/sensor_model.sv
// behavioural sensor on the gpio pins: edges the capture pin, times strobe.
// assumes fire is a one-cycle request from the bench on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sensor_model #(
  parameter int DLY = 5  // answer latency, cycles
) (
  // clock
  input wire logic sys_clk,
  // pins
  input wire logic strobe,
  output logic capture_in,
  // bench side
  input wire logic fire,
  output int width
);
  int pend = 0;  // cycles until the edge
  int cnt = 0;  // strobe high so far
  initial capture_in = 1'b0;
  initial width = 0;
  // delayed transition; pin holds far longer than the filter needs
  always @(posedge sys_clk) begin
    if (fire) pend <= DLY;
    else if (pend != 0) begin
      pend <= pend - 1;
      if (pend == 1) capture_in <= !capture_in;
    end
  end
  // strobe width in cycles, latched as it falls
  always @(posedge sys_clk) begin
    if (strobe) cnt <= cnt + 1;
    else if (cnt != 0) begin
      width <= cnt;
      cnt <= 0;
    end
  end
endmodule // sensor_model
`default_nettype wire

// file: verif/dual_rtc_alarm_capture_bench.sv
// self-checking bench: apb register rows, then alarm, periodic, strobe,
// capture, seconds alarm and reset cases; sources are sys_clk derived.
`timescale 1ns/1ps
`default_nettype none
module dual_rtc_alarm_capture_bench
  import rtc_pkg::*;
;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, cv;
  logic pready, pslverr, er, lfx = 0, lfo = 0, fire = 0;
  logic [1:0] power_mode = 2'h0;
  logic capture_in, timed_strobe_output, wake_req, irq;
  int miscompares = 0, compares = 0, cyc = 0, width, t0;
  // register rows: address, write, expected read, expected error
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic r;} row_t;
  row_t rows[9] = '{
    '{OFS_MASK, 32'hffff_ffff, 32'h0000_001f, 1'b0},
    '{OFS_STB_WIDTH, 32'h0000_01ff, 32'h0000_00ff, 1'b0},
    '{OFS_CTRL, 32'h0000_00f4, 32'h0000_00f4, 1'b0},
    '{OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{OFS_CAP_COUNT, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{OFS_NOW_FINE, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{OFS_SEC_ALARM, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{8'h34, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  logic [31:0] pctl[3] = '{32'h0000_0402, 32'h0000_0406, 32'h0000_0412};
  int pgap[3] = '{60 * 8, 60 * 12, 60 * 16};
  // exponent 4: a unit outlasts the capture-to-read gap
  logic [31:0] cc[3] = '{32'h0000_1042, 32'h0000_3042, 32'h0000_0042};
  logic [31:0] cs[3] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0000};
  dual_rtc_alarm_capture u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_freq_crystal(lfx), .low_freq_internal_osc(lfo),
    .power_mode(power_mode), .wake_req(wake_req), .capture_in(capture_in),
    .timed_strobe_output(timed_strobe_output), .irq(irq));
  sensor_model #(.DLY(5)) u_model (.sys_clk(sys_clk),
    .strobe(timed_strobe_output), .capture_in(capture_in), .fire(fire),
    .width(width));
  initial forever #20 sys_clk = ~sys_clk;
  // crystal period 8 cycles, oscillator 12: phases above the filter
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lfx <= (cyc % 8) < 4;
    lfo <= (cyc % 12) < 6;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge;
  // only the watchdog ends a wait that never completes
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    do @(posedge sys_clk); while (irq !== 1'b1);
  endtask
  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well beyond the whole sequence
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd, rows[i].e);
      chk({31'h0, er}, {31'h0, rows[i].r});
    end
    $display("test rows done");
    // absolute flexible alarm, mask gating, write-one-to-clear
    apb(1'b1, OFS_FLEX_ALARM, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_0202);
    wait_irq();
    apb(1'b0, OFS_FLEX_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, OFS_MASK, 32'h0000_0000);
    apb(1'b1, OFS_MASK, 32'h0000_001f);
    apb(1'b1, OFS_STATUS, 32'h0000_0002);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    // fine alarm: count 1 at phase 2 of a four-tick unit
    apb(1'b1, OFS_FLEX_COUNT, 32'h0000_0000);
    apb(1'b1, OFS_FLEX_ALARM, 32'h0000_0001);
    apb(1'b1, OFS_FLEX_FINE, 32'h0000_0002);
    apb(1'b1, OFS_CTRL, 32'h0000_0222);
    wait_irq();
    apb(1'b0, OFS_NOW_FINE, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, OFS_FLEX_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_STATUS, 32'h0000_001f);
    $display("test alarm done");
    // periodic spacing for crystal, oscillator and exponent 1
    foreach (pctl[i]) begin
      apb(1'b1, OFS_CTRL, pctl[i]);
      wait_irq();
      t0 = cyc;
      apb(1'b1, OFS_STATUS, 32'h0000_001f);
      wait_irq();
      chk(cyc - t0, pgap[i]);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_STATUS, 32'h0000_001f);
    end
    $display("test periodic done");
    // strobe width 0 then 2 units, second in hibernate
    for (int i = 0; i < 2; i++) begin
      power_mode <= (i == 0) ? PM_ACTIVE : PM_HIBERNATE;
      apb(1'b1, OFS_STB_WIDTH, 32'(2 * i));
      apb(1'b1, OFS_FLEX_COUNT, 32'h0000_0000);
      apb(1'b1, OFS_STB_TARGET, 32'h0000_0004);
      apb(1'b1, OFS_CTRL, 32'h0000_0802);
      wait_irq();
      do @(posedge sys_clk); while (timed_strobe_output !== 1'b0);
      @(posedge sys_clk);
      chk(width, 8 * (i == 0 ? 1 : 2));
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0008);
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_STATUS, 32'h0000_001f);
    end
    $display("test strobe done");
    // capture on rising, falling, then refused when disabled
    power_mode <= PM_CORE_GATED;
    foreach (cc[i]) begin
      apb(1'b1, OFS_CTRL, cc[i]);
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (20) @(posedge sys_clk);
      apb(1'b0, OFS_CAP_COUNT, 32'h0000_0000);
      cv = rd;
      apb(1'b0, OFS_FLEX_COUNT, 32'h0000_0000);
      if (cs[i] != 0) chk({31'h0, rd - cv <= 1}, 32'h0000_0001);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rd, cs[i]);
      chk({31'h0, wake_req}, {31'h0, cs[i][4]});
      apb(1'b1, OFS_STATUS, 32'h0000_001f);
    end
    $display("test capture done");
    // seconds alarm by writing a matching count, in shutdown
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    power_mode <= PM_SHUTDOWN;
    apb(1'b1, OFS_SEC_ALARM, 32'h0000_0009);
    apb(1'b1, OFS_CTRL, 32'h0000_0101);
    apb(1'b1, OFS_SEC_COUNT, 32'h0000_0009);
    apb(1'b0, OFS_SEC_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0009);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk({31'h0, wake_req}, 32'h0000_0001);
    $display("test seconds done");
    // reset in mid-run clears registers and outputs
    power_mode <= PM_ACTIVE;
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(prdata, 32'h0000_0000);
    chk({31'h0, wake_req}, 32'h0000_0000);
    nrst <= 1'b1;
    apb(1'b0, OFS_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({30'h0, irq, timed_strobe_output}, 32'h0000_0000);
    $display("test reset done");
    final_report();
  end
endmodule // dual_rtc_alarm_capture_bench
`default_nettype wire
